// ===== ptr_rng.sv
// Purpose: health-gated true random word source
// Assumes: raw bits arrive synchronous with raw_valid, consumer takes words by valid/ready
// Notes: every failure is sticky until rstn; the buffer is flushed on any failure
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ptr_rng
  import ptr_pkg::*;
#(
  parameter int RUN = ptr_pkg::RUN_LIMIT,
  parameter int WIN = ptr_pkg::WIN_LEN
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic raw_bit,
  input wire logic raw_valid,
  output logic raw_ready,
  output logic [ptr_pkg::WORD_W-1:0] rnd_word,
  output logic rnd_valid,
  input wire logic rnd_ready,
  output ptr_pkg::ptr_stat_s status
);
  import ptr_pkg::*;
  // elaboration check: quarantine must end before the next word completes
  if (RUN < 2 || RUN > WORD_W * FOLD) begin : g_bad_run
    $error("RUN out of range");
  end
  // elaboration check: the ones limits must fit inside one window
  if (WIN < 16 || ONES_HI >= WIN) begin : g_bad_win
    $error("WIN too small");
  end

  localparam int RW = $clog2(RUN + 1);
  localparam int WW = $clog2(WIN + 1);
  localparam int BW = $clog2(WORD_W * FOLD + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // raw intake
  logic take;                 // raw bit accepted this cycle
  ptr_state_e state_r;        // gate state
  logic tot_fail_r;           // stuck source seen
  logic st_fail_r;            // statistics defect seen
  assign take = raw_valid && raw_ready && state_r != PTR_ST_FAIL;

  ////////////////////////////////////////////////////////////////////////////////
  // total failure: run of identical raw bits
  logic last_r;               // previous raw bit
  logic [RW-1:0] run_r;       // current run length
  logic tot_hit;
  assign tot_hit = take && raw_bit == last_r && run_r == RW'(RUN - 1);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      last_r <= 1'b0;
      run_r <= '0;
    end else if (take) begin
      last_r <= raw_bit;
      run_r <= (raw_bit == last_r) ? run_r + 1'b1 : RW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // online test: ones count per window
  logic [WW-1:0] wcnt_r;      // bits in current window
  logic [WW-1:0] ones_r;      // ones in current window
  logic [WW-1:0] ones_fin;    // count including this bit
  logic win_end, win_bad;
  assign ones_fin = ones_r + WW'(raw_bit);
  assign win_end = take && wcnt_r == WW'(WIN - 1);
  assign win_bad = ones_fin < WW'(ONES_LO) || ones_fin > WW'(ONES_HI);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wcnt_r <= '0;
      ones_r <= '0;
    end else if (win_end) begin
      wcnt_r <= '0;
      ones_r <= '0;
    end else if (take) begin
      wcnt_r <= wcnt_r + 1'b1;
      ones_r <= ones_fin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // gate state machine
  ptr_state_e state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PTR_ST_POWERUP: begin
        if (tot_hit || (win_end && win_bad)) begin
          state_nxt = PTR_ST_FAIL;
        end else if (win_end) begin
          state_nxt = PTR_ST_RUN;
        end
      end
      PTR_ST_RUN: begin
        if (tot_hit || (win_end && win_bad)) begin
          state_nxt = PTR_ST_FAIL;
        end
      end
      PTR_ST_FAIL: state_nxt = PTR_ST_FAIL;
      default: state_nxt = PTR_ST_FAIL;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= PTR_ST_POWERUP;
      tot_fail_r <= 1'b0;
      st_fail_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tot_fail_r <= tot_fail_r || tot_hit;
      st_fail_r <= st_fail_r || (win_end && win_bad && state_r != PTR_ST_FAIL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // post-processing: xor fold and word assembly
  logic fold_r;               // partial xor of current group
  logic [BW-1:0] bcnt_r;      // raw bits in current word
  logic [WORD_W-1:0] asm_r;   // word under assembly
  logic fold_last, word_done, fbit;
  assign fold_last = bcnt_r[0] == 1'b1;  // second bit of a pair
  assign fbit = fold_r ^ raw_bit;
  assign word_done = take && bcnt_r == BW'(WORD_W * FOLD - 1);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fold_r <= 1'b0;
      bcnt_r <= '0;
      asm_r <= '0;
    end else if (take) begin
      fold_r <= fold_last ? 1'b0 : raw_bit;
      bcnt_r <= word_done ? '0 : bcnt_r + 1'b1;
      // shift folded bits into 32-bit word
      if (fold_last) begin
        asm_r <= {asm_r[WORD_W-2:0], fbit};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // quarantine: a finished word waits RUN clean raw bits, so a stuck run that
  // started inside it is caught before it can leave
  logic pend_v_r;             // word waiting
  logic [WORD_W-1:0] pend_r;  // the waiting word
  logic [RW-1:0] q_r;         // clean raw bits seen since completion
  logic q_done, push, f_ready, flush;
  assign q_done = pend_v_r && q_r == RW'(RUN);
  // nothing enters the buffer unless tests pass
  assign push = q_done && state_r == PTR_ST_RUN && !tot_hit;
  assign flush = state_r == PTR_ST_FAIL;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_v_r <= 1'b0;
      pend_r <= '0;
      q_r <= '0;
    end else if (state_nxt == PTR_ST_FAIL) begin
      pend_v_r <= 1'b0;
      q_r <= '0;
    end else if (word_done) begin
      pend_v_r <= 1'b1;
      pend_r <= {asm_r[WORD_W-2:0], fbit};
      q_r <= '0;
    end else if (q_done && (f_ready || state_r == PTR_ST_POWERUP)) begin
      // before the first pass the word is dropped, not kept
      pend_v_r <= 1'b0;
    end else if (pend_v_r && take && !q_done) begin
      q_r <= q_r + 1'b1;
    end
  end

  // back-pressure: stop raw intake while a quarantined word cannot leave
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      raw_ready <= 1'b0;
    end else begin
      raw_ready <= state_nxt != PTR_ST_FAIL && !(q_done && !f_ready)
        && !(pend_v_r && q_r == RW'(RUN - 1) && take);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // buffer and output stage
  logic f_valid, f_pop;
  logic [WORD_W-1:0] f_data;
  assign f_pop = f_valid && (!rnd_valid || rnd_ready) && !flush;

  ptr_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) ptr_fifo_i (
    .clock(clock),
    .rstn(rstn),
    .flush(flush),
    .in_valid(push),
    .in_ready(f_ready),
    .in_data(pend_r),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rnd_valid <= 1'b0;
      rnd_word <= '0;
    end else if (flush || state_nxt == PTR_ST_FAIL) begin
      rnd_valid <= 1'b0;
      rnd_word <= '0;
    end else if (f_pop) begin
      rnd_valid <= 1'b1;
      rnd_word <= f_data;
    end else if (rnd_ready) begin
      rnd_valid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
    end else begin
      status.total_fail <= tot_fail_r || tot_hit;
      status.stat_fail <= st_fail_r || (win_end && win_bad);
      status.test_ok <= state_nxt == PTR_ST_RUN;
    end
  end
endmodule : ptr_rng
`default_nettype wire

// ===== ptr_pkg.sv
// Purpose: shared constants and types of the gated true random number source
// Assumes: one raw entropy bit per accepted cycle, 40 MHz system clock
// Notes: test limits are plain defaults and may be tuned per process corner
package ptr_pkg;
  // delivered word width
  localparam int WORD_W = 32;
  // raw bits folded into one internal bit by the xor compressor
  localparam int FOLD = 2;
  // identical raw bits in a row that mean the source is dead
  localparam int RUN_LIMIT = 32;
  // raw bits per online test window
  localparam int WIN_LEN = 256;
  // lowest and highest tolerated count of ones in a window
  localparam int ONES_LO = 96;
  localparam int ONES_HI = 160;
  // output buffer depth in words
  localparam int FIFO_DEPTH = 8;

  // gate state
  typedef enum logic [1:0] {
    PTR_ST_POWERUP = 2'b00,  // first window running, output blocked
    PTR_ST_RUN = 2'b01,      // tests passing, words may leave
    PTR_ST_FAIL = 2'b10      // sticky, only reset leaves it
  } ptr_state_e;

  // status seen by the consumer
  typedef struct packed {
    logic total_fail;  // source stuck
    logic stat_fail;   // window statistics out of range
    logic test_ok;     // power-up test passed and no failure
  } ptr_stat_s;
endpackage : ptr_pkg

// ===== ptr_fifo.sv
// Purpose: small word fifo with registered read data
// Assumes: single clock, flush has priority over push and pop
// Notes: show-ahead, out_data is valid whenever out_valid is high
`timescale 1ns/1ps
`default_nettype none
module ptr_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  // elaboration check: the pointers wrap cleanly only for a power-of-two depth
  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end
  logic [W-1:0] mem [D];       // storage
  logic [AW-1:0] wp_r, rp_r;   // pointers
  logic [AW:0] cnt_r;          // fill level
  logic push, pop;
  logic [AW-1:0] rp_use;       // read address this cycle

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign rp_use = pop ? rp_r + 1'b1 : rp_r;

  // honest full and empty from the fill level
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (flush) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wp_r <= push ? wp_r + 1'b1 : wp_r;
      rp_r <= rp_use;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      in_ready <= (cnt_r + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(D);
      // a word written this cycle is not readable until the next
      out_valid <= (cnt_r - (AW+1)'(pop)) != '0;
    end
  end

  // storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // registered read data, follows the read pointer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_data <= '0;
    end else begin
      out_data <= mem[rp_use];
    end
  end
endmodule : ptr_fifo
`default_nettype wire

// ===== ptr_dummy_unused.sv
`timescale 1ns/1ps

// ===== ptr_rng_properties.sv
// Purpose: concurrent checks on the gated random word source
// Assumes: one clock, rstn asynchronous and active low
// Notes: helper counters mirror the raw intake to predict the health flags
`timescale 1ns/1ps
`default_nettype none
module ptr_rng_properties
  import ptr_pkg::*;
#(
  parameter int RUN = 32,
  parameter int WIN = 256
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic raw_bit,
  input wire logic raw_valid,
  input wire logic raw_ready,
  input wire logic [ptr_pkg::WORD_W-1:0] rnd_word,
  input wire logic rnd_valid,
  input wire logic rnd_ready,
  input wire ptr_pkg::ptr_stat_s status
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic acc, bad_f, last_r, stuck, win_end, in_rng; // intake and health views
  int run_r, win_r, ones_r, ones_nxt; // run length, window position, ones so far
  assign acc = raw_valid && raw_ready;
  assign bad_f = status.total_fail || status.stat_fail;
  assign ones_nxt = ones_r + int'(raw_bit);
  assign stuck = acc && raw_bit == last_r && run_r == RUN - 1;
  assign win_end = acc && win_r == WIN - 1;
  assign in_rng = ones_nxt >= ONES_LO && ones_nxt <= ONES_HI;
  ////////////////////////////////////////
  // mirror of the run and window counters, counted over accepted bits only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      last_r <= 1'b0;
      run_r <= 0;
      win_r <= 0;
      ones_r <= 0;
    end else if (acc) begin
      last_r <= raw_bit;
      run_r <= (raw_bit == last_r && run_r != 0) ? run_r + 1 : 1;
      win_r <= win_end ? 0 : win_r + 1;
      ones_r <= win_end ? 0 : ones_nxt;
    end
  end
  ////////////////////////////////////////
  a_stuck_run_flag: assert property (stuck |=> status.total_fail)
    else $error("stuck run not flagged");
  a_window_out_range: assert property (win_end && !in_rng |=> status.stat_fail)
    else $error("window out of range not flagged");
  a_window_pass_ok: assert property (win_end && in_rng && !bad_f && !stuck |=> status.test_ok)
    else $error("passing window did not set test_ok");
  a_ok_only_window: assert property (!status.test_ok && !win_end |=> !status.test_ok)
    else $error("test_ok rose off a window end");
  a_fail_blocks_out: assert property (bad_f |=> !rnd_valid)
    else $error("word offered after failure");
  a_fail_stops_in: assert property (bad_f |=> !raw_ready)
    else $error("intake open after failure");
  a_stat_flag_sticky: assert property (!$fell(status.stat_fail) && !$fell(status.total_fail))
    else $error("failure flag cleared");
  a_ok_no_fail: assert property (status.test_ok |-> !bad_f)
    else $error("test_ok with failure");
  a_word_held_stable: assert property (rnd_valid && !rnd_ready |=> bad_f || (rnd_valid && $stable(rnd_word)))
    else $error("word changed before taken");
  a_valid_after_ok: assert property (rnd_valid |-> status.test_ok || $past(status.test_ok))
    else $error("word before power-up pass");
endmodule : ptr_rng_properties
`default_nettype wire

// ===== ptr_sink.sv
// Purpose: consumer of random words beside the gated source
// Assumes: a word is taken on any rising clock edge with valid and ready high
// Notes: stall makes the consumer slow so the word buffer fills
`timescale 1ns/1ps
`default_nettype none
module ptr_sink (
  input wire logic clock,
  input wire logic rstn,
  input wire logic stall,
  input wire logic rnd_valid,
  output logic rnd_ready,
  output int got
);
  // ready follows stall one cycle late, like a registered consumer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rnd_ready <= 1'b0;
      got <= 0;
    end else begin
      rnd_ready <= !stall;
      if (rnd_valid && rnd_ready) begin
        got <= got + 1;
      end
    end
  end
endmodule : ptr_sink
`default_nettype wire

// ===== ptr_rng_tb.sv
// Purpose: self-checking bench for the gated random word source
// Assumes: 40 MHz clock, inputs driven 2 ns after the rising edge
// Notes: random raw bits have runs cut one short of the stuck limit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module ptr_rng_tb;
  import ptr_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, raw_bit = 1'b0, raw_valid = 1'b0, stall = 1'b0, b, last;
  logic raw_ready, rnd_valid, rnd_ready, tk;
  logic [WORD_W-1:0] rnd_word, w;
  ptr_stat_s status;
  int bad_count = 0, checked = 0, seed = 83559, got, ones, run, g0;
  always #12.5 clock = ~clock;
  ptr_rng #(.RUN(32), .WIN(256)) ptr_rng_i (.clock(clock), .rstn(rstn), .raw_bit(raw_bit),
    .raw_valid(raw_valid), .raw_ready(raw_ready), .rnd_word(rnd_word),
    .rnd_valid(rnd_valid), .rnd_ready(rnd_ready), .status(status));
  ptr_sink ptr_sink_i (.clock(clock), .rstn(rstn), .stall(stall), .rnd_valid(rnd_valid),
    .rnd_ready(rnd_ready), .got(got));
  // verdict and end of run
  task results();
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // 0 too many ones, 1 too few ones, 2 stuck low
  function automatic logic pat(int k, int i);
    return (k == 0) ? (i % 3 != 2) : (k == 1) ? (i % 3 == 2) : 1'b0;
  endfunction : pat
  // reset held 20 cycles, released just after an edge
  task rst();
    rstn = 1'b0;
    raw_valid = 1'b0;
    repeat (20) @(posedge clock);
    #2 rstn = 1'b1;
  endtask : rst
  // offer one bit; raw_ready is settled here and holds to the next edge
  task send(input logic v);
    int n;
    logic take;
    raw_bit = v;
    raw_valid = 1'b1;
    stall = 1'($random(seed));
    n = 0;
    do begin
      take = raw_ready;
      @(posedge clock);
      #2 n++;
    end while (!take && n < 40);
    if (!take) raw_valid = 1'b0;
  endtask : send
  // hang guard, far beyond the expected run time
  initial begin
    #1000000 bad_count++;
    results();
  end
  initial begin
    rst();
    ones = 0;
    run = 0;
    last = 1'b0;
    for (int i = 0; i < 1500; i++) begin
      b = 1'($random(seed));
      // corner: stop each run one bit short of the stuck limit
      if (run == 31 && b == last) b = !b;
      run = (b == last) ? run + 1 : 1;
      last = b;
      if (i < 256) ones += b;
      send(b);
      if (i == 254) begin
        `CHK("early ok", 1'b0, status.test_ok)
        `CHK("early words", 0, got)
      end
    end
    `CHK("pass", ones >= ONES_LO && ones <= ONES_HI, status.test_ok)
    `CHK("words", 1'b1, got > 0)
    // corner: consumer stalls so buffer and quarantine fill and intake stops
    stall = 1'b1;
    raw_bit = !raw_bit;
    repeat (1200) begin
      tk = raw_ready;
      @(posedge clock);
      #2 if (tk) raw_bit = !raw_bit;
    end
    raw_valid = 1'b0;
    `CHK("intake stopped", 1'b0, raw_ready)
    g0 = got;
    w = '0;
    stall = 1'b0;
    repeat (40) begin
      if (rnd_valid && rnd_ready) w = rnd_word;
      @(posedge clock);
      #2;
    end
    // output register, full buffer and the quarantined word all arrive
    `CHK("kept words", g0 + FIFO_DEPTH + 2, got)
    // alternating raw bits fold to all ones
    `CHK("last word", 32'hffffffff, w)
    // stuck source: count words only up to the moment of detection
    g0 = -1;
    for (int i = 0; i < 40; i++) begin
      send(1'b1);
      if (status.total_fail && g0 < 0) g0 = got;
    end
    stall = 1'b0;
    repeat (20) @(posedge clock);
    `CHK("stuck flag", 1'b1, status.total_fail)
    `CHK("flushed", g0, got)
    for (int k = 0; k < 3; k++) begin
      rst();
      for (int i = 0; i < 256; i++) send(pat(k, i));
      repeat (2) @(posedge clock);
      `CHK("stat flag", k < 2, status.stat_fail)
      `CHK("total flag", k == 2, status.total_fail)
      `CHK("ok flag", 1'b0, status.test_ok)
      `CHK("no words", 0, got)
    end
    results();
  end
endmodule : ptr_rng_tb
bind ptr_rng ptr_rng_properties #(.RUN(RUN), .WIN(WIN)) ptr_rng_properties_i (
  .clock(clock), .rstn(rstn), .raw_bit(raw_bit), .raw_valid(raw_valid),
  .raw_ready(raw_ready), .rnd_word(rnd_word), .rnd_valid(rnd_valid),
  .rnd_ready(rnd_ready), .status(status));
`default_nettype wire
